// >>> rtl/lcf_pkg.sv
// Constants, register map and types shared by the logic cluster design.
package lcf_pkg;

  localparam int NCELLS = 10;
  localparam int LUT_W = 16;
  localparam int NROW = 6;
  localparam int NSRC = 8;
  localparam int ADDR_W = 8;

  // Register map, byte addresses; cell tables and cell settings are arrays of words.
  localparam logic [1:0] LUT_BLOCK = 2'h0;
  localparam logic [1:0] CFG_BLOCK = 2'h1;
  localparam logic [7:0] CLUSTER_CTL_OFS = 8'h80;
  localparam logic [7:0] STATUS_OFS = 8'h84;

  // Per-cell settings word.
  localparam int CFG_W = 17;
  localparam int FF_TYPE_POS = 0;
  localparam int CLK_SEL_POS = 2;
  localparam int CLR_SEL_POS = 3;
  localparam int ALOAD_EN_POS = 4;
  localparam int SYNC_EN_POS = 5;
  localparam int ARITH_POS = 6;
  localparam int PACK_POS = 7;
  localparam int LUT_CHAIN_POS = 8;
  localparam int REG_CHAIN_POS = 9;
  localparam int OSEL_A_POS = 10;
  localparam int OSEL_B_POS = 11;
  localparam int OSEL_L_POS = 12;
  localparam int LSEL_POS = 13;
  localparam logic [CFG_W-1:0] CELL_CFG_RST = 17'h1E000;
  localparam logic [LUT_W-1:0] LUT_RST = 16'h0000;

  // Cluster control word: two clock sources with their edge, and the device reset enable.
  localparam int CC_W = 9;
  localparam int SRC_ONE_POS = 0;
  localparam int POL_ONE_POS = 3;
  localparam int SRC_TWO_POS = 4;
  localparam int POL_TWO_POS = 7;
  localparam int DEVRST_EN_POS = 8;
  localparam logic [CC_W-1:0] CLUSTER_CTL_RST = 9'h110;

  localparam int STATUS_RES_POS = 16;
  localparam int STATUS_MIX_POS = 31;
  localparam logic READY_RST = 1'h1;

  typedef enum logic [1:0] {
    FF_D = 2'b00,
    FF_T = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } lcf_ff_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_RDWAIT = 1'b1
  } lcf_bus_t;

endpackage : lcf_pkg

// >>> rtl/lcf_logic_cluster.sv
// One logic cluster: ten table cells, cluster control generator and its register slave.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Ten cells share one local interconnect and one set of cluster controls.
// - Each cell has a sixteen-entry table giving any function of four inputs.
// - Controls: two clocks, two enables, two clears, sclr, aload, sload, add/sub.
// - Cluster clocks come from six row clocks or two local lines.
// - Each cluster clock is tied to its own clock enable.
// - A low clock enable stops its cluster clock; registers hold.
// - Mixed rising and falling edge use takes both cluster clocks.
// - Asynchronous load with high load data presets the register to one.
// - Each register can act as D, T, JK or SR flip-flop.
// - Register inputs include data, load data from cell input four, controls.
// - Combinational use bypasses the register straight to the outputs.
// - Three outputs each choose table or register result independently.
// - Packing option feeds the register back into its own table.
// - Each table result cascades to the next cell in the cluster.
// - Each register output chains to the next register for shifting.
// - Each cell reaches others over local and direct-link outputs.
// - Add/subtract select makes cells compute A plus B or A minus B.
// - Subtract inverts B bits and forces the lowest carry-in to one.
// - Asynchronous clear wins over asynchronous load or preset.
// - Enabled device-wide reset clears every register over all controls.
module lcf_logic_cluster (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [5:0] rowClk,
  input wire logic [1:0] localClk,
  input wire logic clkEnaOne,
  input wire logic clkEnaTwo,
  input wire logic asyncClrOne,
  input wire logic asyncClrTwo,
  input wire logic syncClr,
  input wire logic asyncLoad,
  input wire logic syncLoad,
  input wire logic addNotSub,
  input wire logic deviceWideReset_n,
  input wire logic [9:0] cellInA,
  input wire logic [9:0] cellInB,
  input wire logic [9:0] cellInC,
  input wire logic [9:0] cellInputFour,
  input wire logic lutChainIn,
  input wire logic regChainIn,
  output logic [9:0] routeOutA,
  output logic [9:0] routeOutB,
  output logic [9:0] localOut,
  output logic lutChainOut,
  output logic regChainOut,
  output logic carryOut
);

  typedef struct packed {
    logic [lcf_pkg::NCELLS-1:0][lcf_pkg::LUT_W-1:0] lut;
    logic [lcf_pkg::NCELLS-1:0][lcf_pkg::CFG_W-1:0] cellCfg;
    logic [lcf_pkg::CC_W-1:0] clusterCtl;
    logic [lcf_pkg::NCELLS-1:0] q;
    logic [lcf_pkg::NCELLS-1:0] res;
    logic [lcf_pkg::NSRC-1:0] srcPrev;
    logic [lcf_pkg::ADDR_W-1:0] addrQ;
    logic wrPend;
    lcf_pkg::lcf_bus_t busState;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [lcf_pkg::NCELLS-1:0] routeA;
    logic [lcf_pkg::NCELLS-1:0] routeB;
    logic [lcf_pkg::NCELLS-1:0] localOut;
    logic lutChainOut;
    logic regChainOut;
    logic carryOut;
  } lcf_state_t;

  lcf_state_t s_r;
  lcf_state_t s_nxt;

  logic [lcf_pkg::NSRC-1:0] srcNow;
  logic [1:0] ena;
  logic [1:0] tick;
  logic [2:0] srcSel;
  logic fallEdge;
  logic edgeHit;
  logic edgeMix;
  logic devReset;
  logic [lcf_pkg::CFG_W-1:0] cfg;
  logic [3:0] lsel;
  logic inA;
  logic inC;
  logic lutVal;
  logic bEff;
  logic cin;
  logic sum;
  logic cout;
  logic arith;
  logic result;
  logic dIn;
  logic qCur;
  logic qNew;
  logic aclr;
  logic prevLut;
  logic prevQ;
  logic prevCarry;
  logic prevArith;
  logic [lcf_pkg::ADDR_W-1:0] wa;
  logic [lcf_pkg::ADDR_W-1:0] ra;
  logic [31:0] rd;

  always_comb
  begin
    s_nxt = s_r;
    srcNow = {localClk, rowClk};
    ena = {clkEnaTwo, clkEnaOne};
    tick = 2'h0;
    srcSel = 3'h0;
    fallEdge = 1'h0;
    edgeHit = 1'h0;
    cfg = '0;
    lsel = 4'h0;
    inA = 1'h0;
    inC = 1'h0;
    lutVal = 1'h0;
    bEff = 1'h0;
    cin = 1'h0;
    sum = 1'h0;
    cout = 1'h0;
    arith = 1'h0;
    result = 1'h0;
    dIn = 1'h0;
    qCur = 1'h0;
    qNew = 1'h0;
    aclr = 1'h0;
    wa = s_r.addrQ;
    ra = s_r.addrQ;
    rd = 32'h0000_0000;
    // Control generator: two clocks with their enables plus six local controls, ten at most.
    for (int k = 0; k < 2; k++)
    begin
      srcSel = s_r.clusterCtl[(k * 4) +: 3];
      fallEdge = s_r.clusterCtl[(k * 4) + 3];
      edgeHit = fallEdge ? (s_r.srcPrev[srcSel] & ~srcNow[srcSel]) :
                           (~s_r.srcPrev[srcSel] & srcNow[srcSel]);
      // A deasserted enable swallows the edge, so nothing on that clock moves.
      tick[k] = edgeHit & ena[k];
    end
    s_nxt.srcPrev = srcNow;
    // Mixed edges are only possible by spending both cluster clocks on one source.
    edgeMix = (s_r.clusterCtl[lcf_pkg::SRC_ONE_POS +: 3] == s_r.clusterCtl[lcf_pkg::SRC_TWO_POS +: 3])
              && (s_r.clusterCtl[lcf_pkg::POL_ONE_POS] != s_r.clusterCtl[lcf_pkg::POL_TWO_POS]);
    devReset = s_r.clusterCtl[lcf_pkg::DEVRST_EN_POS] & ~deviceWideReset_n;

    prevLut = lutChainIn;
    prevQ = regChainIn;
    prevCarry = 1'h0;
    prevArith = 1'h0;
    for (int i = 0; i < lcf_pkg::NCELLS; i++)
    begin
      cfg = s_r.cellCfg[i];
      lsel = cfg[lcf_pkg::LSEL_POS +: 4];
      // Local feedback uses the registered local outputs, so no combinational loop forms.
      inA = (lsel < 4'hA) ? s_r.localOut[lsel] : cellInA[i];
      if (cfg[lcf_pkg::LUT_CHAIN_POS])
      begin
        inA = prevLut;
      end
      qCur = s_r.q[i];
      inC = cfg[lcf_pkg::PACK_POS] ? qCur : cellInC[i];
      lutVal = s_r.lut[i][{cellInputFour[i], inC, cellInB[i], inA}];
      arith = cfg[lcf_pkg::ARITH_POS];
      bEff = cellInB[i] ^ ~addNotSub;
      // Only the first cell takes its carry-in from the select; a chain started
      // further up starts with carry zero.
      if (i == 0)
      begin
        cin = ~addNotSub;
      end
      else
      begin
        cin = prevArith & prevCarry;
      end
      sum = inA ^ bEff ^ cin;
      cout = (inA & bEff) | (cin & (inA ^ bEff));
      result = arith ? sum : lutVal;
      dIn = cfg[lcf_pkg::REG_CHAIN_POS] ? prevQ : result;
      aclr = cfg[lcf_pkg::CLR_SEL_POS] ? asyncClrTwo : asyncClrOne;
      // The controls are sampled on mclk, so an "asynchronous" clear acts at the next edge.
      // The priority chain below is fixed: device reset, clear, load, then clocked behaviour.
      // A cell never clocked keeps its value however the table inputs move.
      qNew = qCur;
      if (devReset)
      begin
        qNew = 1'h0;
      end
      else if (aclr)
      begin
        qNew = 1'h0;
      end
      else if (cfg[lcf_pkg::ALOAD_EN_POS] && asyncLoad)
      begin
        qNew = cellInputFour[i];
      end
      else if (tick[cfg[lcf_pkg::CLK_SEL_POS]])
      begin
        if (cfg[lcf_pkg::SYNC_EN_POS] && syncClr)
        begin
          qNew = 1'h0;
        end
        else if (cfg[lcf_pkg::SYNC_EN_POS] && syncLoad)
        begin
          qNew = cellInputFour[i];
        end
        else
        begin
          case (lcf_pkg::lcf_ff_t'(cfg[lcf_pkg::FF_TYPE_POS +: 2]))
            lcf_pkg::FF_D: qNew = dIn;
            lcf_pkg::FF_T: qNew = qCur ^ dIn;
            lcf_pkg::FF_JK: qNew = (dIn & ~qCur) | (~inC & qCur);
            default: qNew = dIn | (~inC & qCur);
          endcase
        end
      end
      s_nxt.q[i] = qNew;
      s_nxt.res[i] = result;
      // Each output picks the register or the bypassed table result on its own.
      s_nxt.routeA[i] = cfg[lcf_pkg::OSEL_A_POS] ? qCur : result;
      s_nxt.routeB[i] = cfg[lcf_pkg::OSEL_B_POS] ? qCur : result;
      s_nxt.localOut[i] = cfg[lcf_pkg::OSEL_L_POS] ? qCur : result;
      prevLut = result;
      prevQ = qCur;
      prevCarry = cout;
      prevArith = arith;
    end
    s_nxt.lutChainOut = prevLut;
    s_nxt.regChainOut = prevQ;
    s_nxt.carryOut = prevCarry;

    // Write data phase: hwdata is valid in the cycle after the address phase.
    // Unmapped offsets fall through every branch, so such writes change nothing.
    if (s_r.wrPend)
    begin
      if (wa[7:6] == lcf_pkg::LUT_BLOCK && wa[5:2] < 4'hA)
      begin
        s_nxt.lut[wa[5:2]] = hwdata[lcf_pkg::LUT_W-1:0];
      end
      else if (wa[7:6] == lcf_pkg::CFG_BLOCK && wa[5:2] < 4'hA)
      begin
        s_nxt.cellCfg[wa[5:2]] = hwdata[lcf_pkg::CFG_W-1:0];
      end
      else if (wa == lcf_pkg::CLUSTER_CTL_OFS)
      begin
        s_nxt.clusterCtl = hwdata[lcf_pkg::CC_W-1:0];
      end
    end

    // Reads take one wait state so the data reflects a write just before.
    // Unmapped reads leave the default zero in the read word.
    case (s_r.busState)
      lcf_pkg::BUS_RDWAIT:
      begin
        if (ra[7:6] == lcf_pkg::LUT_BLOCK && ra[5:2] < 4'hA)
        begin
          rd = 32'(s_r.lut[ra[5:2]]);
        end
        else if (ra[7:6] == lcf_pkg::CFG_BLOCK && ra[5:2] < 4'hA)
        begin
          rd = 32'(s_r.cellCfg[ra[5:2]]);
        end
        else if (ra == lcf_pkg::CLUSTER_CTL_OFS)
        begin
          rd = 32'(s_r.clusterCtl);
        end
        else if (ra == lcf_pkg::STATUS_OFS)
        begin
          rd = 32'(s_r.q);
          rd[lcf_pkg::STATUS_RES_POS +: lcf_pkg::NCELLS] = s_r.res;
          rd[lcf_pkg::STATUS_MIX_POS] = edgeMix;
        end
        s_nxt.hrdata = rd;
        s_nxt.hreadyout = 1'h1;
        s_nxt.busState = lcf_pkg::BUS_IDLE;
      end
      default:
      begin
        s_nxt.wrPend = 1'h0;
        if (hsel && hready && htrans[1])
        begin
          s_nxt.addrQ = haddr[lcf_pkg::ADDR_W-1:0];
          s_nxt.wrPend = hwrite;
          if (!hwrite)
          begin
            s_nxt.hreadyout = 1'h0;
            s_nxt.busState = lcf_pkg::BUS_RDWAIT;
          end
        end
      end
    endcase
    s_nxt.hresp = 1'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.hreadyout <= lcf_pkg::READY_RST;
      s_r.clusterCtl <= lcf_pkg::CLUSTER_CTL_RST;
      for (int i = 0; i < lcf_pkg::NCELLS; i++)
      begin
        s_r.cellCfg[i] <= lcf_pkg::CELL_CFG_RST;
        s_r.lut[i] <= lcf_pkg::LUT_RST;
      end
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign routeOutA = s_r.routeA;
  assign routeOutB = s_r.routeB;
  assign localOut = s_r.localOut;
  assign lutChainOut = s_r.lutChainOut;
  assign regChainOut = s_r.regChainOut;
  assign carryOut = s_r.carryOut;

endmodule : lcf_logic_cluster

`default_nettype wire

// >>> dv/lcf_logic_cluster_checker.sv
// Concurrent checks on the cluster's bus answers and cell register pins.
`timescale 1ns/1ps
`default_nettype none
module lcf_logic_cluster_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic clkEnaOne,
  input wire logic clkEnaTwo,
  input wire logic asyncClrOne,
  input wire logic asyncClrTwo,
  input wire logic asyncLoad,
  input wire logic deviceWideReset_n,
  input wire logic regChainOut
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence rdTaken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wrTaken;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  // Cell 9 sits on clock one and clear one, so its register shows on the chain output.
  sequence quiet;
    !clkEnaOne && !clkEnaTwo && !asyncClrOne && !asyncClrTwo && !asyncLoad && deviceWideReset_n;
  endsequence
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_read_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
    else $error("read wait is not one cycle");
  a_write_nowait: assert property (wrTaken |=> hreadyout) else $error("write stalled");
  a_rdata_stands: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rdTaken ##0 (haddr[7:0] > 8'h84) |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_enable_hold: assert property (quiet |-> ##2 $stable(regChainOut))
    else $error("register moved with clocks disabled");
  a_clear_wins: assert property (asyncClrOne |-> ##2 !regChainOut)
    else $error("clear did not win");
  a_devreset_clears: assert property (!deviceWideReset_n |-> ##2 !regChainOut)
    else $error("device reset did not clear");
endmodule : lcf_logic_cluster_checker
bind lcf_logic_cluster lcf_logic_cluster_checker chk (.mclk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .clkEnaOne, .clkEnaTwo, .asyncClrOne,
  .asyncClrTwo, .asyncLoad, .deviceWideReset_n, .regChainOut);
`default_nettype wire

// >>> dv/lcf_routing_model.sv
// Row clock source and neighbouring cluster that feed the cluster's far side.
`timescale 1ns/1ps
`default_nettype none
module lcf_routing_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  output logic [5:0] rowClk,
  output logic lutChainIn,
  output logic regChainIn
);
  // The row clock stands low between requests, so each request is one single-cycle pulse: one rising edge, then one falling edge.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rowClk <= 6'h00;
      regChainIn <= 1'b0;
    end
    else
    begin
      rowClk <= {5'h00, tick};
      regChainIn <= regChainIn ^ tick;
    end
  end
  assign lutChainIn = 1'b0;
endmodule : lcf_routing_model
`default_nettype wire

// >>> dv/lcf_logic_cluster_test.sv
// Self-checking bench for the logic cluster through its bus and cell pins.
`timescale 1ns/1ps
`default_nettype none
module lcf_logic_cluster_test;
  logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, tick, nb, pend;
  logic clkEnaOne, asyncClrOne, syncClr, asyncLoad, syncLoad, addNotSub, deviceWideReset_n;
  logic clkEnaTwo, asyncClrTwo;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [5:0] rowClk;
  logic lutChainIn, regChainIn;
  logic [9:0] cellInA, cellInB, cellInC, cellInputFour, q;
  logic [15:0] t [10];
  logic [31:0] expQ [$];
  int errors, total_checks;
  assign hready = hreadyout;
  lcf_logic_cluster dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .rowClk, .localClk(2'h0), .clkEnaOne,
    .clkEnaTwo, .asyncClrOne, .asyncClrTwo, .syncClr, .asyncLoad, .syncLoad,
    .addNotSub, .deviceWideReset_n, .cellInA, .cellInB, .cellInC, .cellInputFour,
    .lutChainIn, .regChainIn, .routeOutA(), .routeOutB(), .localOut(), .lutChainOut(),
    .regChainOut(), .carryOut());
  lcf_routing_model far (.mclk, .rst, .tick, .rowClk, .lutChainIn, .regChainIn);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic cmp_word(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_word
  // The monitor pairs each completed read with the oldest note, so drivers never compare.
  always @(posedge mclk)
  begin
    if (pend && hreadyout)
    begin
      pend = 1'b0;
      cmp_word("read data", expQ.pop_front(), hrdata);
    end
    if (hsel && hready && htrans[1] && !hwrite)
      pend = 1'b1;
  end
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge mclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (!hready);
  endtask : bus
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic cfg_all(logic [16:0] v);
    for (int i = 0; i < lcf_pkg::NCELLS; i++)
      wr(8'h40 + 8'(4 * i), {15'h0000, lcf_pkg::CELL_CFG_RST | v});
  endtask : cfg_all
  task automatic step();
    tick <= 1'b1;
    @(posedge mclk);
    tick <= 1'b0;
    nb = ~nb;
    repeat (3) @(posedge mclk);
  endtask : step
  function automatic logic [9:0] res();
    for (int i = 0; i < 10; i++)
      res[i] = t[i][{cellInputFour[i], cellInC[i], cellInB[i], cellInA[i]}];
  endfunction : res
  function automatic logic [31:0] st(logic [9:0] r, logic [9:0] v);
    return {6'h00, r, 6'h00, v};
  endfunction : st
  function automatic logic [9:0] nxt(int k, logic [9:0] v, logic [9:0] d, logic [9:0] c);
    case (k)
      0: return d;
      1: return v ^ d;
      2: return (d & ~v) | (~c & v);
      default: return d | (~c & v);
    endcase
  endfunction : nxt
  task automatic chk_st();
    rd(lcf_pkg::STATUS_OFS, st(res(), q));
  endtask : chk_st
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
  initial
  begin
    {errors, total_checks} = '0;
    {rst, deviceWideReset_n, addNotSub, clkEnaOne} = 4'hF;
    {hsel, hwrite, tick, nb, pend, asyncClrOne, syncClr, asyncLoad, syncLoad} = '0;
    {clkEnaTwo, asyncClrTwo} = '0;
    {haddr, hwdata, htrans, cellInA, cellInB, cellInC, cellInputFour, q} = '0;
    t = '{default: 16'h0000};
    void'($urandom(33565));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(lcf_pkg::CLUSTER_CTL_OFS, 32'(lcf_pkg::CLUSTER_CTL_RST));
    rd(8'h64, 32'(lcf_pkg::CELL_CFG_RST));
    rd(8'h28, 32'h0);
    wr(lcf_pkg::STATUS_OFS, 32'hFFFFFFFF);
    rd(lcf_pkg::STATUS_OFS, 32'h0);
    rd(8'h88, 32'h0);
    for (int i = 0; i < lcf_pkg::NCELLS; i++)
    begin
      t[i] = 16'($urandom);
      wr(8'(4 * i), {16'h0000, t[i]});
    end
    for (int k = 0; k < 4; k++)
    begin
      cfg_all(17'(k));
      for (int e = 1; e >= 0; e--)
      begin
        clkEnaOne <= (e == 1);
        {cellInA, cellInB, cellInC, cellInputFour} <= 40'({$urandom, $urandom});
        step();
        if (e == 1)
          q = nxt(k, q, res(), cellInC);
        chk_st();
      end
    end
    cfg_all(17'h00010);
    cellInputFour <= 10'h3FF;
    asyncLoad <= 1'b1;
    repeat (2) @(posedge mclk);
    q = 10'h3FF;
    chk_st();
    asyncClrOne <= 1'b1;
    repeat (2) @(posedge mclk);
    {asyncClrOne, asyncLoad} <= 2'h0;
    q = 10'h000;
    chk_st();
    asyncLoad <= 1'b1;
    repeat (2) @(posedge mclk);
    deviceWideReset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    {deviceWideReset_n, asyncLoad} <= 2'h2;
    chk_st();
    cfg_all(17'h00020);
    clkEnaOne <= 1'b1;
    syncLoad <= 1'b1;
    cellInputFour <= 10'($urandom);
    step();
    q = cellInputFour;
    chk_st();
    syncClr <= 1'b1;
    step();
    q = 10'h000;
    chk_st();
    {syncClr, syncLoad} <= 2'h0;
    cfg_all(17'h00210);
    asyncLoad <= 1'b1;
    cellInputFour <= 10'($urandom);
    repeat (2) @(posedge mclk);
    asyncLoad <= 1'b0;
    q = cellInputFour;
    repeat (3)
    begin
      step();
      q = {q[8:0], nb};
      chk_st();
    end
    cfg_all(17'h00040);
    for (int m = 0; m < 2; m++)
    begin
      addNotSub <= (m == 1);
      {cellInA, cellInB} <= 20'($urandom);
      @(posedge mclk);
      rd(lcf_pkg::STATUS_OFS, st((m == 1) ? cellInA + cellInB : cellInA - cellInB, q));
    end
    // Clock two on row line zero; cells on clock two and clear two.
    wr(lcf_pkg::CLUSTER_CTL_OFS, 32'h00000100);
    cfg_all(17'h0000C);
    {clkEnaOne, clkEnaTwo} <= 2'h2;
    {cellInA, cellInB, cellInC, cellInputFour} <= 40'({$urandom, $urandom});
    step();
    chk_st();
    {clkEnaOne, clkEnaTwo} <= 2'h1;
    step();
    q = res();
    chk_st();
    asyncClrTwo <= 1'b1;
    repeat (2) @(posedge mclk);
    asyncClrTwo <= 1'b0;
    q = 10'h000;
    chk_st();
    wr(lcf_pkg::CLUSTER_CTL_OFS, 32'h00000180);
    rd(lcf_pkg::STATUS_OFS, st(res(), q) | 32'h80000000);
    @(posedge mclk);
    close_out();
  end
endmodule : lcf_logic_cluster_test
`default_nettype wire
